// File: core_model.sv
// core stand-in: executes wait and stop, counts its clocks
`timescale 1ns/1ns
module core_model (
  input  wire logic        clk,         // clock
  input  wire logic        coreReset_n, // core reset
  input  wire logic        coreClkEn,   // core gate
  input  wire logic [1:0]  exec,        // 1 wait, 2 stop
  output wire logic        waitInstr,   // wait pulse
  output wire logic        stopInstr,   // stop pulse
  output logic      [15:0] ticks        // clocks seen
);
  assign waitInstr = coreReset_n && coreClkEn && exec == 2'h1;
  assign stopInstr = coreReset_n && coreClkEn && exec == 2'h2;
  always @(posedge clk) begin
    if (!coreReset_n)
      ticks <= 16'h0000;
    else if (coreClkEn)
      ticks <= ticks + 16'h0001;
  end
endmodule

// File: reset_clock_mode_control.v
// reset sequencing, low-power clock gating and mode word for the chip
`timescale 1ns/1ns
`include "reset_clock_mode_control_regs.vh"

// Summary of operation
// - hold reset 96 clocks, POR 2^21 clocks
// - POR or pin resets core and peripherals
// - watchdog/software reset keeps boot select bit
// - software reset bit resets part, reads zero
// - debug: watchdog off, motor outputs optional off
// - wait stops core and memory clocks
// - wait options: halt watchdog, motor outputs off
// - stop gates core, memory, peripheral clocks
// - stop options: halt watchdog, halt CAN
// - CAN activity or interrupt leaves stop
// - software may block wait and stop
// - four 16-bit registers cleared only by POR
// - per-peripheral clock gating by software
// - secure flash blocks external access
// - mode word bit layout and reset values
// - run mode supplies every clock not gated off by debug or software enables
module reset_clock_mode_control #(
  // power-on extension; shorter values only to keep simulations brief
  parameter [21:0] POR_EXT_CYCLES = `EXT_POR_CYCLES
) (
  input  wire        clk,             // system clock, 250 MHz
  input  wire        reset_n,         // internal power-on reset, active low
  input  wire        resetPin_n,      // external reset pin, active low
  input  wire        watchdogReset,   // watchdog timeout request
  input  wire        flashSecure,     // flash security state
  input  wire        debugActive,     // debugger owns the core
  input  wire        waitInstr,       // core executes wait, pulse
  input  wire        stopInstr,       // core executes stop, pulse
  input  wire        canWake,         // CAN activity
  input  wire        irqWake,         // any ungated interrupt
  input  wire        extAccessReq,    // external flash access request
  input  wire        regWrite,        // control register write strobe
  input  wire [15:0] regWdata,        // control register write data
  input  wire        omwWrite,        // mode word write strobe
  input  wire [15:0] omwWdata,        // mode word write data
  input  wire [1:0]  scrSel,          // software register select
  input  wire        scrWrite,        // software register write strobe
  input  wire [15:0] scrWdata,        // software register write data
  input  wire [15:0] periphClkEn,     // per-peripheral clock enables
  input  wire        waitHaltWdog,    // wait option: halt watchdog
  input  wire        waitMotorOff,    // wait option: motor outputs off
  input  wire        debugMotorOff,   // debug option: motor outputs off
  input  wire        stopHaltWdog,    // stop option: halt watchdog
  input  wire        stopHaltCan,     // stop option: halt CAN
  output wire [15:0] ctrlRdata,       // control register read data
  output reg  [15:0] operatingModeWord, // mode word read data
  output wire [15:0] scrRdata,        // selected software register
  output reg         coreReset_n,     // core reset, active low
  output reg         periphReset_n,   // peripheral reset, active low
  output reg  [1:0]  resetCause,      // last reset cause
  output wire        coreClkEn,       // core clock gate
  output wire        memClkEn,        // memory clock gate
  output wire [15:0] periphClkGate,   // peripheral clock gates
  output wire        watchdogClkEn,   // watchdog clock gate
  output wire        canClkEn,        // CAN clock gate
  output wire        motorOff,        // force motor outputs off
  output wire        extAccessGrant,  // external flash access allowed
  output wire [1:0]  modeState        // current mode
);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  reg [1:0] pinSync_q;
  reg [1:0] secSync_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync_q <= 2'h0;
      secSync_q <= 2'h0;
    end else begin
      pinSync_q <= {pinSync_q[0], ~resetPin_n};
      secSync_q <= {secSync_q[0], flashSecure};
    end
  end
  wire pinReset = pinSync_q[1];
  wire secure   = secSync_q[1];

  // --------------------------------------------------------------
  // control register
  // --------------------------------------------------------------
  reg  [15:0] ctrl_q;
  wire swReset = regWrite & regWdata[`CTRL_SOFTWARE_RESET_TRIGGER];
  assign ctrlRdata = ctrl_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      ctrl_q <= `REG_RESET;
    else if (!coreReset_n)
      ctrl_q <= `REG_RESET;
    else if (regWrite)
      ctrl_q <= regWdata & `CTRL_WRITE_MASK;
  end

  // --------------------------------------------------------------
  // reset sequencing
  // --------------------------------------------------------------
  reg  [21:0] extCnt_q;
  wire        warmReset = watchdogReset | swReset;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      extCnt_q      <= POR_EXT_CYCLES;
      resetCause    <= `CAUSE_POR;
      coreReset_n   <= 1'b0;
      periphReset_n <= 1'b0;
    end else begin
      if (pinReset) begin
        extCnt_q      <= `EXT_SHORT_CYCLES;
        resetCause    <= `CAUSE_PIN;
        coreReset_n   <= 1'b0;
        periphReset_n <= 1'b0;
      end else if (warmReset && coreReset_n) begin
        extCnt_q      <= `EXT_SHORT_CYCLES;
        resetCause    <= `CAUSE_WARM;
        coreReset_n   <= 1'b0;
        periphReset_n <= 1'b0;
      end else if (extCnt_q != `EXT_CNT_ZERO) begin
        extCnt_q <= extCnt_q - `EXT_CNT_ONE;
        if (extCnt_q == `EXT_CNT_ONE) begin
          coreReset_n   <= 1'b1;
          periphReset_n <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // operating mode word
  // --------------------------------------------------------------
  reg bootCaught_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // reset value, boot bits caught below
      operatingModeWord <= `OMW_RESET;
      bootCaught_q      <= 1'b0;
    end else if (!bootCaught_q && coreReset_n) begin
      bootCaught_q <= 1'b1;
      operatingModeWord[`OMW_BOOT_A] <= secure;
      operatingModeWord[`OMW_BOOT_B] <= secure;
    end else if (pinReset) begin
      operatingModeWord <= `OMW_RESET;
      bootCaught_q      <= 1'b0;
    end else if (warmReset && coreReset_n) begin
      operatingModeWord <= `OMW_RESET |
        ({15'h0000, operatingModeWord[`OMW_BOOT_A]});
    end else if (omwWrite && coreReset_n) begin
      // bit 2 and unused bits read zero
      operatingModeWord <= omwWdata & `OMW_WRITE_MASK;
    end
  end

  // --------------------------------------------------------------
  // general-purpose registers
  // --------------------------------------------------------------
  reg [15:0] scrMem [0:3];
  integer i;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 4; i = i + 1)
        scrMem[i] <= `REG_RESET;
    end else if (scrWrite) begin
      scrMem[scrSel] <= scrWdata;
    end
  end
  assign scrRdata = scrMem[scrSel];

  // --------------------------------------------------------------
  // mode state machine
  // --------------------------------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      `ST_RESET: begin
        if (coreReset_n)
          state_d = `ST_RUN;
      end
      `ST_RUN: begin
        if (stopInstr && !ctrl_q[`CTRL_STOP_DIS])
          state_d = `ST_STOP;
        else if (waitInstr && !ctrl_q[`CTRL_WAIT_DIS])
          state_d = `ST_WAIT;
      end
      `ST_WAIT: begin
        if (irqWake)
          state_d = `ST_RUN;
      end
      `ST_STOP: begin
        if (canWake || irqWake)
          state_d = `ST_RUN;
      end
      default: state_d = `ST_RESET;
    endcase
    if (!coreReset_n)
      state_d = `ST_RESET;
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      state_q <= `ST_RESET;
    else
      state_q <= state_d;
  end
  assign modeState = state_q;

  // --------------------------------------------------------------
  // clock gating
  // --------------------------------------------------------------
  wire inWait = (state_q == `ST_WAIT);
  wire inStop = (state_q == `ST_STOP);
  assign coreClkEn = ~inWait & ~inStop;
  assign memClkEn  = ~inWait & ~inStop;
  assign periphClkGate = inStop ? 16'h0000 : periphClkEn;
  assign watchdogClkEn = ~debugActive & ~(inWait & waitHaltWdog)
                         & ~(inStop & stopHaltWdog);
  // CAN runs in stop to see wake activity unless halted
  assign canClkEn = ~(inStop & stopHaltCan);
  assign motorOff = (debugActive & debugMotorOff) | (inWait & waitMotorOff);
  assign extAccessGrant = extAccessReq & ~secure;

endmodule

// File: reset_clock_mode_control_asserts.sv
// checker on the reset, clock and mode control ports
`timescale 1ns/1ns
module reset_clock_mode_control_asserts (
  input wire logic        clk,           // clock
  input wire logic        reset_n,       // por
  input wire logic        watchdogReset, // warm request
  input wire logic        debugActive,   // debugger
  input wire logic        stopInstr,     // stop pulse
  input wire logic        canWake,       // can wake
  input wire logic        regWrite,      // ctrl strobe
  input wire logic [15:0] regWdata,      // ctrl data
  input wire logic        stopHaltCan,   // stop option
  input wire logic [15:0] ctrlRdata,     // ctrl read
  input wire logic        coreReset_n,   // core reset
  input wire logic        periphReset_n, // periph reset
  input wire logic        coreClkEn,     // core gate
  input wire logic        memClkEn,      // memory gate
  input wire logic        watchdogClkEn, // wdog gate
  input wire logic        canClkEn,      // can gate
  input wire logic [1:0]  modeState      // mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_run_clocks_on: assert property (modeState == 2'h1 |-> coreClkEn && memClkEn)
    else $error("run lost a clock");
  a_wait_core_off: assert property (modeState == 2'h2 |-> !coreClkEn && !memClkEn)
    else $error("wait kept core clock");
  a_stop_core_off: assert property (modeState == 2'h3 |-> !coreClkEn && !memClkEn)
    else $error("stop kept core clock");
  a_stop_entry: assert property (
    modeState == 2'h1 && stopInstr && !ctrlRdata[2] && !regWrite && !watchdogReset
    |=> modeState == 2'h3) else $error("stop not entered");
  a_stop_wake: assert property (
    modeState == 2'h3 && canWake && !watchdogReset |=> modeState == 2'h1)
    else $error("no wake from stop");
  a_stop_can_opt: assert property (modeState == 2'h3 |-> canClkEn == !stopHaltCan)
    else $error("can gate wrong in stop");
  a_debug_wdog_off: assert property (debugActive |-> !watchdogClkEn)
    else $error("watchdog runs in debug");
  a_swrst_reads0: assert property (ctrlRdata[4] == 1'b0)
    else $error("reset bit read as one");
  a_swrst_hold: assert property (
    modeState == 2'h1 && regWrite && regWdata[4] && !watchdogReset
    |=> !periphReset_n ##95 !coreReset_n ##1 coreReset_n) else $error("warm reset span");
endmodule

bind reset_clock_mode_control
  reset_clock_mode_control_asserts reset_clock_mode_control_asserts_inst (
  .clk, .reset_n, .watchdogReset, .debugActive, .stopInstr, .canWake, .regWrite, .regWdata,
  .stopHaltCan, .ctrlRdata, .coreReset_n, .periphReset_n, .coreClkEn, .memClkEn,
  .watchdogClkEn, .canClkEn, .modeState);

// File: reset_clock_mode_control_regs.vh
// constants for the reset, clock and mode control block
`ifndef RESET_CLOCK_MODE_CONTROL_REGS_VH
`define RESET_CLOCK_MODE_CONTROL_REGS_VH
// reset extension counts
`define EXT_SHORT_CYCLES   22'h00_0060
`define EXT_POR_CYCLES     22'h20_0000
`define EXT_CNT_ONE        22'h00_0001
`define EXT_CNT_ZERO       22'h00_0000
// operating mode word fields
`define OMW_RESET          16'h0000
`define OMW_WRITE_MASK     16'h81FB
`define OMW_BOOT_A         0
`define OMW_BOOT_B         1
// control register layout
`define CTRL_WAIT_DIS      0
`define CTRL_STOP_DIS      2
`define CTRL_SOFTWARE_RESET_TRIGGER        4
`define CTRL_WRITE_MASK    16'h000F
`define REG_RESET          16'h0000
// sequencer states
`define ST_RESET           2'h0
`define ST_RUN             2'h1
`define ST_WAIT            2'h2
`define ST_STOP            2'h3
// reset cause codes
`define CAUSE_NONE         2'h0
`define CAUSE_POR          2'h1
`define CAUSE_PIN          2'h2
`define CAUSE_WARM         2'h3
`endif

// File: tb_reset_clock_mode_control.sv
// self-checking bench for the reset, clock and mode control block
`timescale 1ns/1ns
module tb_reset_clock_mode_control;
  logic clk, reset_n, resetPin_n, debugActive, canWake, irqWake, regWrite, omwWrite;
  logic scrWrite, waitHaltWdog, stopHaltWdog, stopHaltCan;
  logic watchdogReset, flashSecure, extAccessReq, waitMotorOff, debugMotorOff;
  logic [1:0] scrSel, exec;
  logic [15:0] regWdata, omwWdata, scrWdata, periphClkEn;
  wire coreReset_n, periphReset_n, coreClkEn, watchdogClkEn, canClkEn, waitInstr, stopInstr;
  wire memClkEn, motorOff, extAccessGrant;
  wire [1:0] resetCause, modeState;
  wire [15:0] ctrlRdata, operatingModeWord, scrRdata, periphClkGate, ticks;
  int n_mismatch, num_checks, n;
  // shortened power-on extension keeps the run brief
  localparam logic [21:0] POR_CYCLES = 22'h00_1000;
  reset_clock_mode_control #(.POR_EXT_CYCLES(POR_CYCLES)) reset_clock_mode_control_inst (
    .clk, .reset_n, .resetPin_n, .watchdogReset, .flashSecure, .debugActive,
    .waitInstr, .stopInstr, .canWake, .irqWake, .extAccessReq, .regWrite, .regWdata,
    .omwWrite, .omwWdata, .scrSel, .scrWrite, .scrWdata, .periphClkEn, .waitHaltWdog,
    .waitMotorOff, .debugMotorOff, .stopHaltWdog, .stopHaltCan, .ctrlRdata,
    .operatingModeWord, .scrRdata, .coreReset_n, .periphReset_n, .resetCause, .coreClkEn,
    .memClkEn, .periphClkGate, .watchdogClkEn, .canClkEn, .motorOff, .extAccessGrant,
    .modeState);
  core_model core_model_inst (.clk, .coreReset_n, .coreClkEn, .exec, .waitInstr, .stopInstr,
    .ticks);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic issue(input logic [1:0] op);
    exec = op;
    step();
    exec = 2'h0;
  endtask
  task automatic run_wait;
    for (n = 0; n < 20000 && coreReset_n !== 1'b1; n++) step();
    step();
  endtask
  task automatic t_por;
    step(200);
    check(coreReset_n, 16'h0000);
    run_wait();
    check(16'(n + 200 == POR_CYCLES), 16'h0001);
    check(operatingModeWord, 16'h0003);
    check(resetCause, 2'h1);
    check(scrRdata, 16'h0000);
    $display("power-on test done");
  endtask
  task automatic t_regs;
    omwWrite = 1'b1;
    omwWdata = 16'hFFFF;
    for (int i = 0; i < 4; i++) begin
      scrWrite = 1'b1;
      scrSel = 2'(i);
      scrWdata = 16'hA5A0 + 16'(i);
      step();
      omwWrite = 1'b0;
    end
    scrWrite = 1'b0;
    check(operatingModeWord, 16'h81FB);
    for (int i = 0; i < 4; i++) begin
      scrSel = 2'(i);
      #1 check(scrRdata, 16'hA5A0 + 16'(i));
    end
    check(periphClkGate, periphClkEn);
    check(coreClkEn, 16'h0001);
    check(memClkEn, 16'h0001);
    debugActive = 1'b1;
    debugMotorOff = 1'b1;
    step();
    check(watchdogClkEn, 16'h0000);
    check(motorOff, 16'h0001);
    check(periphClkGate, 16'h5A3C);
    debugMotorOff = 1'b0;
    step();
    check(motorOff, 16'h0000);
    debugActive = 1'b0;
    extAccessReq = 1'b1;
    step();
    check(watchdogClkEn, 16'h0001);
    check(extAccessGrant, 16'h0000);
    flashSecure = 1'b0;
    step(2);
    check(extAccessGrant, 16'h0001);
    flashSecure = 1'b1;
    extAccessReq = 1'b0;
    step(2);
    $display("register test done");
  endtask
  task automatic t_modes;
    issue(2'h2);
    check(modeState, 2'h3);
    check(memClkEn, 16'h0000);
    check(periphClkGate, 16'h0000);
    check(watchdogClkEn, 16'h0000);
    n = ticks;
    step(5);
    check(ticks, 16'(n));
    check(canClkEn, 16'h0000);
    canWake = 1'b1;
    step();
    canWake = 1'b0;
    check(modeState, 2'h1);
    {stopHaltWdog, stopHaltCan} = 2'h0;
    issue(2'h2);
    check(modeState, 2'h3);
    check(canClkEn, 16'h0001);
    check(watchdogClkEn, 16'h0001);
    irqWake = 1'b1;
    step();
    irqWake = 1'b0;
    check(modeState, 2'h1);
    waitMotorOff = 1'b1;
    issue(2'h1);
    check(modeState, 2'h2);
    check(memClkEn, 16'h0000);
    check(periphClkGate, 16'h5A3C);
    check(watchdogClkEn, 16'h0000);
    check(motorOff, 16'h0001);
    irqWake = 1'b1;
    step();
    irqWake = 1'b0;
    waitMotorOff = 1'b0;
    check(modeState, 2'h1);
    regWrite = 1'b1;
    regWdata = 16'h0005;
    step();
    regWrite = 1'b0;
    check(ctrlRdata, 16'h0005);
    issue(2'h1);
    check(modeState, 2'h1);
    step();
    issue(2'h2);
    step();
    check(modeState, 2'h1);
    check(coreClkEn, 16'h0001);
    $display("mode test done");
  endtask
  task automatic t_resets;
    omwWrite = 1'b1;
    omwWdata = 16'h0003;
    step();
    omwWrite = 1'b0;
    regWrite = 1'b1;
    regWdata = 16'h0010;
    step();
    regWrite = 1'b0;
    check(ctrlRdata, 16'h0000);
    for (n = 0; n < 200 && coreReset_n !== 1'b1; n++) step();
    check(16'(n), 16'h0060);
    step();
    check(operatingModeWord, 16'h0001);
    check(resetCause, 2'h3);
    watchdogReset = 1'b1;
    step();
    watchdogReset = 1'b0;
    check(periphReset_n, 16'h0000);
    for (n = 0; n < 200 && coreReset_n !== 1'b1; n++) step();
    check(16'(n), 16'h0060);
    step();
    check(operatingModeWord, 16'h0001);
    check(modeState, 2'h1);
    resetPin_n = 1'b0;
    step(5);
    check(periphReset_n, 16'h0000);
    resetPin_n = 1'b1;
    run_wait();
    check(resetCause, 2'h2);
    check(operatingModeWord, 16'h0003);
    check(scrRdata, 16'hA5A3);
    $display("reset test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
  initial begin
    {reset_n, debugActive, canWake, irqWake, regWrite, omwWrite, scrWrite} = '0;
    {watchdogReset, extAccessReq, waitMotorOff, debugMotorOff} = '0;
    {resetPin_n, flashSecure, waitHaltWdog, stopHaltWdog, stopHaltCan} = 5'h1F;
    {scrSel, exec, regWdata, omwWdata, scrWdata} = '0;
    periphClkEn = 16'h5A3C;
    step(3);
    reset_n = 1'b1;
    t_por();
    t_regs();
    t_modes();
    t_resets();
    conclude();
  end
endmodule
